// ===== hdl/lsd_map.vh
// Opcode patterns, field values, cycle counts and kind codes of the logic and string decoder
`ifndef LSD_MAP_VH
`define LSD_MAP_VH
`define LSD_OP_AND       6'h08
`define LSD_OP_OR        6'h02
`define LSD_OP_XOR       6'h0c
`define LSD_OP_TEST_RM   7'h42
`define LSD_OP_GRP3      7'h7b
`define LSD_OP_TEST_ACC  7'h54
`define LSD_OP_SMOVE     7'h52
`define LSD_OP_SCMP      7'h53
`define LSD_OP_SSCAN     7'h57
`define LSD_OP_SLOAD     7'h56
`define LSD_OP_SSTORE    7'h55
`define LSD_OP_SIN       7'h36
`define LSD_OP_SOUT      7'h37
`define LSD_OP_REP       8'hf2
`define LSD_OP_CREP      7'h79
`define LSD_SUB_TEST     3'h0
`define LSD_SUB_INV      3'h2
`define LSD_MOD_REG      2'h3
`define LSD_CYC_RR       16'h0003
`define LSD_CYC_RM       16'h000a
`define LSD_CYC_IMM_R    16'h0004
`define LSD_CYC_IMM_M    16'h000a
`define LSD_CYC_ACC_B    16'h0003
`define LSD_CYC_ACC_W    16'h0004
`define LSD_CYC_WORD_ADJ 16'h0004
`define LSD_CYC_MOVE     16'h000e
`define LSD_CYC_CMP      16'h0016
`define LSD_CYC_SCAN     16'h000f
`define LSD_CYC_LOAD     16'h000c
`define LSD_CYC_STORE    16'h000a
`define LSD_CYC_PORT     16'h000e
`define LSD_RMOVE_BASE   16'h0008
`define LSD_RMOVE_STEP   16'h0008
`define LSD_RLOAD_BASE   16'h0006
`define LSD_RLOAD_STEP   16'h000b
`define LSD_RCMP_BASE    16'h0005
`define LSD_RCMP_STEP    16'h0016
`define LSD_RSCAN_BASE   16'h0005
`define LSD_RSCAN_STEP   16'h000f
`define LSD_K_NONE       4'h0
`define LSD_K_AND        4'h1
`define LSD_K_OR         4'h2
`define LSD_K_XOR        4'h3
`define LSD_K_TEST       4'h4
`define LSD_K_INV        4'h5
`define LSD_K_MOVE       4'h6
`define LSD_K_CMP        4'h7
`define LSD_K_SCAN       4'h8
`define LSD_K_LOAD       4'h9
`define LSD_K_STORE      4'ha
`define LSD_K_PIN        4'hb
`define LSD_K_POUT       4'hc
`endif

// ===== hdl/lsd_decoder.v
// Logic and string instruction decoder with cycle-count model
// How it works
// - And/or/xor register forms: 3 or 10
// - Register test sets flags only, 3/10
// - Group byte: field 0 test, 2 invert
// - Accumulator immediate test, 3/4 cycles
// - Narrow bus: add 4 per word memory logic form and unrepeated move
// - String move takes 14 cycles
// - String compare takes 22 cycles
// - String scan takes 15 cycles
// - String load takes 12 cycles
// - String store takes 10 cycles
// - Port input string takes 14 cycles
// - Port output string takes 14 cycles
// - Repeat: move 8+8n, load 6+11n
// - Conditional repeat: compare 5+22n, scan 5+15n
`timescale 1ns/1ns
`include "lsd_map.vh"
module lsd_decoder (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        dec_valid_i,
  input  wire [7:0]  prefix_i,
  input  wire        prefix_valid_i,
  input  wire [7:0]  opcode_i,
  input  wire [7:0]  modrm_i,
  input  wire [15:0] count_register_i,
  input  wire        narrow_bus_i,
  output reg         dec_done_o,
  output reg  [3:0]  kind_o,
  output reg         word_op_o,
  output reg         reg_is_dest_o,
  output reg         writes_result_o,
  output reg         mem_operand_o,
  output reg         repeat_prefix_o,
  output reg         conditional_repeat_prefix_o,
  output reg         repeat_on_equal_o,
  output reg  [1:0]  imm_bytes_o,
  output reg  [15:0] cycles_o,
  output reg         illegal_o
);
  reg [3:0]  kind_nxt;
  reg [15:0] cyc_nxt;
  reg [15:0] adj;
  reg        wrt_nxt;
  reg        ill_nxt;
  reg        rep_nxt;
  reg        crep_nxt;
  reg        mem_nxt;
  reg [1:0]  imm_nxt;
  wire       w_bit = opcode_i[0];
  wire       mem   = (modrm_i[7:6] != `LSD_MOD_REG);
  wire       is_rep  = prefix_valid_i && (prefix_i == `LSD_OP_REP);
  wire       is_crep = prefix_valid_i && (prefix_i[7:1] == `LSD_OP_CREP);

  always @* begin
    kind_nxt = `LSD_K_NONE;
    cyc_nxt  = 16'h0000;
    wrt_nxt  = 1'b1;
    ill_nxt  = 1'b0;
    rep_nxt  = 1'b0;
    crep_nxt = 1'b0;
    mem_nxt  = 1'b0;
    imm_nxt  = 2'h0;
    // Word memory penalty on the narrow bus
    adj = (narrow_bus_i && w_bit) ? `LSD_CYC_WORD_ADJ : 16'h0000;
    if (opcode_i[7:2] == `LSD_OP_AND || opcode_i[7:2] == `LSD_OP_OR ||
        opcode_i[7:2] == `LSD_OP_XOR) begin
      kind_nxt = (opcode_i[7:2] == `LSD_OP_AND) ? `LSD_K_AND :
                 (opcode_i[7:2] == `LSD_OP_OR) ? `LSD_K_OR : `LSD_K_XOR;
      mem_nxt  = mem;
      cyc_nxt  = mem ? (`LSD_CYC_RM + adj) : `LSD_CYC_RR;
    end else if (opcode_i[7:1] == `LSD_OP_TEST_RM) begin
      kind_nxt = `LSD_K_TEST;
      wrt_nxt  = 1'b0;
      mem_nxt  = mem;
      cyc_nxt  = mem ? (`LSD_CYC_RM + adj) : `LSD_CYC_RR;
    end else if (opcode_i[7:1] == `LSD_OP_GRP3) begin
      mem_nxt = mem;
      if (modrm_i[5:3] == `LSD_SUB_TEST) begin
        kind_nxt = `LSD_K_TEST;
        wrt_nxt  = 1'b0;
        imm_nxt  = w_bit ? 2'h2 : 2'h1;
        cyc_nxt  = mem ? (`LSD_CYC_IMM_M + adj) : `LSD_CYC_IMM_R;
      end else if (modrm_i[5:3] == `LSD_SUB_INV) begin
        kind_nxt = `LSD_K_INV;
        cyc_nxt  = mem ? (`LSD_CYC_RM + adj) : `LSD_CYC_RR;
      end else begin
        ill_nxt = 1'b1;
      end
    end else if (opcode_i[7:1] == `LSD_OP_TEST_ACC) begin
      kind_nxt = `LSD_K_TEST;
      wrt_nxt  = 1'b0;
      imm_nxt  = w_bit ? 2'h2 : 2'h1;
      cyc_nxt  = w_bit ? `LSD_CYC_ACC_W : `LSD_CYC_ACC_B;
    end else begin
      mem_nxt = 1'b1;
      case (opcode_i[7:1])
        `LSD_OP_SMOVE: begin
          kind_nxt = `LSD_K_MOVE;
          rep_nxt  = is_rep;
          cyc_nxt  = is_rep ? (`LSD_RMOVE_BASE + `LSD_RMOVE_STEP * count_register_i) :
                     (`LSD_CYC_MOVE + adj);
        end
        `LSD_OP_SCMP: begin
          kind_nxt = `LSD_K_CMP;
          crep_nxt = is_crep;
          cyc_nxt  = is_crep ? (`LSD_RCMP_BASE + `LSD_RCMP_STEP * count_register_i) :
                     `LSD_CYC_CMP;
        end
        `LSD_OP_SSCAN: begin
          kind_nxt = `LSD_K_SCAN;
          crep_nxt = is_crep;
          cyc_nxt  = is_crep ? (`LSD_RSCAN_BASE + `LSD_RSCAN_STEP * count_register_i) :
                     `LSD_CYC_SCAN;
        end
        `LSD_OP_SLOAD: begin
          kind_nxt = `LSD_K_LOAD;
          rep_nxt  = is_rep;
          cyc_nxt  = is_rep ? (`LSD_RLOAD_BASE + `LSD_RLOAD_STEP * count_register_i) :
                     `LSD_CYC_LOAD;
        end
        `LSD_OP_SSTORE: begin
          kind_nxt = `LSD_K_STORE;
          cyc_nxt  = `LSD_CYC_STORE;
        end
        `LSD_OP_SIN: begin
          kind_nxt = `LSD_K_PIN;
          cyc_nxt  = `LSD_CYC_PORT;
        end
        `LSD_OP_SOUT: begin
          kind_nxt = `LSD_K_POUT;
          cyc_nxt  = `LSD_CYC_PORT;
        end
        default: begin
          mem_nxt = 1'b0;
          ill_nxt = 1'b1;
        end
      endcase
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_done_o                  <= 1'b0;
      kind_o                      <= `LSD_K_NONE;
      word_op_o                   <= 1'b0;
      reg_is_dest_o               <= 1'b0;
      writes_result_o             <= 1'b0;
      mem_operand_o               <= 1'b0;
      repeat_prefix_o             <= 1'b0;
      conditional_repeat_prefix_o <= 1'b0;
      repeat_on_equal_o           <= 1'b0;
      imm_bytes_o                 <= 2'h0;
      cycles_o                    <= 16'h0000;
      illegal_o                   <= 1'b0;
    end else begin
      dec_done_o <= dec_valid_i;
      if (dec_valid_i) begin
        kind_o                      <= kind_nxt;
        word_op_o                   <= w_bit;
        reg_is_dest_o               <= opcode_i[1];
        writes_result_o             <= wrt_nxt & ~ill_nxt;
        mem_operand_o               <= mem_nxt;
        repeat_prefix_o             <= rep_nxt;
        conditional_repeat_prefix_o <= crep_nxt;
        repeat_on_equal_o           <= crep_nxt & prefix_i[0];
        imm_bytes_o                 <= imm_nxt;
        cycles_o                    <= cyc_nxt;
        illegal_o                   <= ill_nxt;
      end
    end
  end
endmodule // lsd_decoder

// ===== tb/lsd_decoder_chk.sv
// Port assertions for the decoder
`timescale 1ns/1ns
module lsd_decoder_chk (
  input wire        clk_sys_i, rst_n_i, dec_valid_i, prefix_valid_i, narrow_bus_i, dec_done_o,
  input wire        writes_result_o, repeat_prefix_o, conditional_repeat_prefix_o, repeat_on_equal_o, reg_is_dest_o,
  input wire [7:0]  prefix_i, opcode_i, modrm_i,
  input wire [15:0] count_register_i, cycles_o,
  input wire [3:0]  kind_o,
  input wire [1:0]  imm_bytes_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire v = dec_valid_i;
  AST_DONE: assert property (v |=> dec_done_o) else $error("done missing");
  AST_IDLE: assert property (!v |=> !dec_done_o && $stable(cycles_o)) else $error("idle change");
  AST_AND: assert property (v && opcode_i[7:2] == 6'h08 |=> kind_o == 4'h1 && reg_is_dest_o == $past(opcode_i[1]))
    else $error("and decode");
  AST_TEST: assert property (v && opcode_i[7:1] == 7'h42 && modrm_i[7:6] == 2'h3 |=>
    kind_o == 4'h4 && !writes_result_o && cycles_o == 16'h0003) else $error("test decode");
  AST_INV: assert property (v && opcode_i[7:1] == 7'h7b && modrm_i[5:3] == 3'h2 |=> kind_o == 4'h5)
    else $error("invert decode");
  AST_ACC: assert property (v && opcode_i[7:1] == 7'h54 |=> imm_bytes_o == 2'h1 + $past(opcode_i[0]))
    else $error("acc data bytes");
  AST_ADJ: assert property (v && !prefix_valid_i && narrow_bus_i && opcode_i == 8'ha5 |=> cycles_o == 16'h0012)
    else $error("word adjust");
  AST_CMP: assert property (v && !prefix_valid_i && opcode_i[7:1] == 7'h53 |=> cycles_o == 16'h0016)
    else $error("compare cycles");
  AST_PORT: assert property (v && opcode_i[7:2] == 6'h1b |=> cycles_o == 16'h000e) else $error("port cycles");
  AST_REP: assert property (v && prefix_valid_i && prefix_i == 8'hf2 && opcode_i[7:1] == 7'h56 |=>
    repeat_prefix_o && cycles_o == 16'h0006 + 16'h000b * $past(count_register_i)) else $error("rep load");
  AST_CREP: assert property (v && prefix_valid_i && prefix_i[7:1] == 7'h79 && opcode_i[7:1] == 7'h57 |=>
    conditional_repeat_prefix_o && repeat_on_equal_o == $past(prefix_i[0])) else $error("cond rep");
  cover property (v && prefix_valid_i && opcode_i[7:1] == 7'h52);
  cover property (v ##1 v);
  cover property (v && narrow_bus_i && opcode_i[0] && modrm_i[7:6] != 2'h3);
endmodule // lsd_decoder_chk
bind lsd_decoder lsd_decoder_chk i_chk (.*);

// ===== tb/lsd_decoder_test.sv
// Random and corner-case bench for the decoder
`timescale 1ns/1ns
module lsd_decoder_test;
  reg         clk_sys_i = 1'b0, rst_n_i = 1'b0, dec_valid_i = 1'b0, prefix_valid_i = 1'b0, narrow_bus_i = 1'b0;
  reg  [7:0]  prefix_i = 8'h00, opcode_i = 8'h00, modrm_i = 8'h00, o;
  reg  [15:0] count_register_i = 16'h0000;
  wire        dec_done_o, word_op_o, reg_is_dest_o, writes_result_o, mem_operand_o, illegal_o;
  wire        repeat_prefix_o, conditional_repeat_prefix_o, repeat_on_equal_o;
  wire [3:0]  kind_o;
  wire [1:0]  imm_bytes_o;
  wire [15:0] cycles_o;
  reg  [21:0] exp_r = 22'h0;
  reg  [31:0] r, q;
  integer     seed = 32'hf64cbc5d, n_errors = 0, n_tests = 0, i;
  localparam [103:0] OPS = {8'h6e, 8'h6c, 8'haa, 8'hac, 8'hae, 8'ha6, 8'ha4, 8'ha8, 8'hf6, 8'h84, 8'h30, 8'h08, 8'h20};
  always #10 clk_sys_i = ~clk_sys_i;
  lsd_decoder i_dut (.*);
  function [21:0] model(input [7:0] p, input pv, input [7:0] o, input [7:0] m, input [15:0] n, input nb);
    reg [3:0] k;
    reg [15:0] c, a, rm;
    reg rp, cr;
    begin
      rp = pv && p == 8'hf2;
      cr = pv && p[7:1] == 7'h79;
      a = (nb && o[0]) ? 16'h0004 : 16'h0000;
      rm = (m[7:6] == 2'h3) ? 16'h0003 : 16'h000a + a;
      casez ({o, m[5:3]})
        11'b001000??_???: {k, c} = {4'h1, rm};
        11'b000010??_???: {k, c} = {4'h2, rm};
        11'b001100??_???: {k, c} = {4'h3, rm};
        11'b1000010?_???: {k, c} = {4'h4, rm};
        11'b1111011?000: {k, c} = {4'h4, rm + (m[7:6] == 2'h3)};
        11'b1111011?010: {k, c} = {4'h5, rm};
        11'b1010100?_???: {k, c} = {4'h4, 16'h0003 + o[0]};
        11'b1010010?_???: {k, c} = {4'h6, rp ? 16'h0008 + 16'h0008 * n : 16'h000e + a};
        11'b1010011?_???: {k, c} = {4'h7, cr ? 16'h0005 + 16'h0016 * n : 16'h0016};
        11'b1010111?_???: {k, c} = {4'h8, cr ? 16'h0005 + 16'h000f * n : 16'h000f};
        11'b1010110?_???: {k, c} = {4'h9, rp ? 16'h0006 + 16'h000b * n : 16'h000c};
        11'b1010101?_???: {k, c} = {4'ha, 16'h000a};
        11'b0110110?_???: {k, c} = {4'hb, 16'h000e};
        11'b0110111?_???: {k, c} = {4'hc, 16'h000e};
        default: {k, c} = {4'h0, 16'h0000};
      endcase
      model = {1'b1, k == 4'h0, k, c};
    end
  endfunction
  // Operand flags: dest, word, memory, writes, immediate bytes
  function [5:0] flags(input [7:0] o, input [7:0] m);
    reg mm;
    begin
      mm = (m[7:6] != 2'h3);
      casez ({o, m[5:3]})
        11'b001000?????: flags = {o[1], o[0], mm, 1'b1, 2'h0};
        11'b000010?????: flags = {o[1], o[0], mm, 1'b1, 2'h0};
        11'b001100?????: flags = {o[1], o[0], mm, 1'b1, 2'h0};
        11'b1000010????: flags = {o[1], o[0], mm, 1'b0, 2'h0};
        11'b1111011?000: flags = {o[1], o[0], mm, 1'b0, o[0], ~o[0]};
        11'b1111011?010: flags = {o[1], o[0], mm, 1'b1, 2'h0};
        11'b1111011????: flags = {o[1], o[0], mm, 1'b0, 2'h0};
        11'b1010100????: flags = {o[1], o[0], 1'b0, 1'b0, o[0], ~o[0]};
        11'b1010010????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b1010011????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b1010111????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b1010110????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b1010101????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b0110110????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        11'b0110111????: flags = {o[1], o[0], 1'b1, 1'b1, 2'h0};
        default:         flags = {o[1], o[0], 1'b0, 1'b0, 2'h0};
      endcase
    end
  endfunction
  reg  [5:0]  exp_f = 6'h0;
  task check(input [21:0] seen, input [21:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task step(input v, input [7:0] p, input pv, input [7:0] op, input [7:0] m, input [15:0] n, input nb);
    begin
      @(posedge clk_sys_i);
      exp_r = dec_valid_i ? model(prefix_i, prefix_valid_i, opcode_i, modrm_i, count_register_i, narrow_bus_i)
                          : {1'b0, exp_r[20:0]};
      exp_f = dec_valid_i ? flags(opcode_i, modrm_i) : exp_f;
      {dec_valid_i, prefix_i, prefix_valid_i, opcode_i, modrm_i, count_register_i, narrow_bus_i} <= {v, p, pv, op, m, n, nb};
      @(negedge clk_sys_i);
      check({dec_done_o, illegal_o, kind_o, cycles_o}, exp_r);
      check({16'h0, reg_is_dest_o, word_op_o, mem_operand_o, writes_result_o, imm_bytes_o}, {16'h0, exp_f});
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    step(1'b1, 8'hf2, 1'b1, 8'ha4, 8'h00, 16'h0003, 1'b0);
    step(1'b1, 8'hf3, 1'b1, 8'ha7, 8'h00, 16'h0000, 1'b1);
    step(1'b1, 8'h00, 1'b0, 8'ha5, 8'h00, 16'h0000, 1'b1);
    step(1'b1, 8'h00, 1'b0, 8'hf7, 8'h28, 16'h0000, 1'b0);
    step(1'b1, 8'hf2, 1'b1, 8'h6f, 8'h00, 16'h0005, 1'b1);
    for (i = 0; i < 3000; i = i + 1) begin
      r = $random(seed);
      q = $random(seed);
      o = (r[19:16] > 4'hc) ? r[7:0] : OPS[8 * r[19:16] +: 8] | (r[1:0] & {r[19:16] < 4'h3, 1'b1});
      step(r[22] | r[23], r[20] ? 8'hf2 : 8'hf3, r[21], o, q[31:24], q[15:0], r[8]);
    end
    step(1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 16'h0000, 1'b0);
    end_sim;
  end
endmodule // lsd_decoder_test
